// *** psim_pkg.sv ***
// constants shared by the slot interrupt controller files
// assumes a 32-bit buffered local data path and active-low board chip selects
package psim_pkg;
   // ==========================================================
   // register map
   localparam int ADDR_W = 4;
   localparam int DATA_W = 32;
   localparam logic [3:0] PEND_OFS = 4'h0;
   localparam logic [3:0] MASK_OFS = 4'h4;
   // ==========================================================
   // source layout: slot s, pin p sits at bit s*LINES+p
   localparam int SLOTS = 3;
   localparam int LINES = 4;
   localparam int SRC_N = 12;
   localparam logic [11:0] MASK_RST = 12'h000;
   localparam logic [11:0] PEND_RST = 12'h000;
   localparam logic [19:0] UNIMPL_ZERO = 20'h00000;
   // ==========================================================
   // chip-select map: buffered regions are selects 0,1,3,4,6,7
   localparam int CS_N = 8;
   localparam logic [7:0] BUF_CS_MAP = 8'hdb;
   localparam int IRQ_CS_IDX = 3;
endpackage

// *** psim_gate_if.sv ***
// signals between the controller and its transceiver gate
// assumes chip selects and disables are synchronous to clk
`timescale 1ns/1ps
interface psim_gate_if;
   logic [7:0] chipSel_n;
   logic [7:0] regionDisable;
   logic hardResetCfg;
   logic irqCtrlOk;
   logic xcvrOpen_n;
   modport gate (
      input chipSel_n,
      input regionDisable,
      input hardResetCfg,
      output irqCtrlOk,
      output xcvrOpen_n
   );
   modport ctrl (
      output chipSel_n,
      output regionDisable,
      output hardResetCfg,
      input irqCtrlOk,
      input xcvrOpen_n
   );
endinterface

// *** psim_xcvr_gate.sv ***
// buffered-side data transceiver enable and controller access qualifier
// assumes a single clock and synchronous active-low reset
`timescale 1ns/1ps
module psim_xcvr_gate (
   input wire logic clk,
   input wire logic rst_n,
   psim_gate_if.gate g
);
   typedef struct packed {
      logic open_n;
   } psim_gate_t;

   psim_gate_t s_r;
   psim_gate_t s_nxt;
   logic [7:0] liveSel;

   // ==========================================================
   // region decode
   // a disabled region's select does not open the transceivers, so an off-board memory can own it
   always_comb begin
      liveSel = ~g.chipSel_n & psim_pkg::BUF_CS_MAP & ~g.regionDisable;
      s_nxt.open_n = !((|liveSel) || g.hardResetCfg);
   end

   assign g.irqCtrlOk = liveSel[psim_pkg::IRQ_CS_IDX];
   assign g.xcvrOpen_n = s_r.open_n;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s_r.open_n <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   xcvr_open_a: assert property ((|(~g.chipSel_n & psim_pkg::BUF_CS_MAP & ~g.regionDisable))
      || g.hardResetCfg |=> !g.xcvrOpen_n)
      else $error("transceivers not opened for buffered access");
   xcvr_shut_a: assert property (!(|(~g.chipSel_n & psim_pkg::BUF_CS_MAP
      & ~g.regionDisable)) && !g.hardResetCfg |=> g.xcvrOpen_n)
      else $error("transceivers open outside a live buffered region");
endmodule

// *** psim_irq_ctrl.sv ***
// slot interrupt controller: pending and mask registers, one host request
// assumes plain level strobes, synchronous to clk, and active-low slot lines
`timescale 1ns/1ps
module psim_irq_ctrl (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] chipSel_n,
   input wire logic [7:0] regionDisable,
   input wire logic hardResetCfg,
   input wire logic [3:0] regAddr,
   input wire logic writeEn_n,
   input wire logic readEn_n,
   input wire logic [31:0] dataIn,
   output logic [31:0] dataOut,
   output logic dataOe,
   input wire logic [3:0] slotLine_n,
   output logic pciIrqToHost_n,
   output logic xcvrEnable_n
);
   typedef struct packed {
      logic [11:0] mask;
      logic [11:0] pend;
      logic [31:0] rdData;
      logic rdOe;
      logic irq_n;
   } psim_state_t;

   psim_state_t s_r;
   psim_state_t s_nxt;
   logic wrHit;
   logic rdHit;

   psim_gate_if gIf ();

   assign gIf.chipSel_n = chipSel_n;
   assign gIf.regionDisable = regionDisable;
   assign gIf.hardResetCfg = hardResetCfg;

   psim_xcvr_gate uGate (
      .clk(clk),
      .rst_n(rst_n),
      .g(gIf.gate)
   );

   // ==========================================================
   // routing: each board line is shared by one pin of every slot,
   // rotated per slot, so one active line lights three sources
   function automatic logic [11:0] psimRoute(input logic [3:0] act);
      logic [11:0] r;
      r = 12'h000;
      for (int s = 0; s < psim_pkg::SLOTS; s++) begin
         for (int p = 0; p < psim_pkg::LINES; p++) begin
            r[s * psim_pkg::LINES + p] = act[(p + s) % psim_pkg::LINES];
         end
      end
      return r;
   endfunction

   // ==========================================================
   // next state
   always_comb begin
      s_nxt = s_r;
      wrHit = gIf.irqCtrlOk && !writeEn_n;
      rdHit = gIf.irqCtrlOk && !readEn_n;
      if (wrHit && regAddr == psim_pkg::MASK_OFS) begin
         s_nxt.mask = dataIn[11:0];
      end
      // pending follows the lines; software clears the source at the slot device
      s_nxt.pend = psimRoute(~slotLine_n) & ~s_r.mask;
      s_nxt.irq_n = !(|(s_r.pend & ~s_r.mask));
      s_nxt.rdOe = rdHit;
      // unmapped offsets answer zero so a stray read never shows stale data
      s_nxt.rdData = 32'h00000000;
      if (rdHit) begin
         unique case (regAddr)
            psim_pkg::PEND_OFS: s_nxt.rdData = {psim_pkg::UNIMPL_ZERO, s_r.pend};
            psim_pkg::MASK_OFS: s_nxt.rdData = {psim_pkg::UNIMPL_ZERO, s_r.mask};
            default: s_nxt.rdData = 32'h00000000;
         endcase
      end
   end

   // only controller state resets here; the transceiver gate resets itself
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s_r.mask <= psim_pkg::MASK_RST;
         s_r.pend <= psim_pkg::PEND_RST;
         s_r.rdData <= 32'h00000000;
         s_r.rdOe <= 1'b0;
         s_r.irq_n <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   // every output is a register copy; the host sees no decode glitches
   assign dataOut = s_r.rdData;
   assign dataOe = s_r.rdOe;
   assign pciIrqToHost_n = s_r.irq_n;
   assign xcvrEnable_n = gIf.xcvrOpen_n;

   // ==========================================================
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   mask_write_a: assert property (wrHit && regAddr == psim_pkg::MASK_OFS
      |=> s_r.mask == $past(dataIn[11:0]))
      else $error("mask write not taken");
   mask_hold_a: assert property (!(wrHit && regAddr == psim_pkg::MASK_OFS)
      |=> $stable(s_r.mask))
      else $error("mask changed without a mask write");
   mask_read_a: assert property (rdHit && regAddr == psim_pkg::MASK_OFS
      |=> dataOe && dataOut == {20'h00000, $past(s_r.mask)})
      else $error("mask read wrong or upper bits not zero");
   pend_read_a: assert property (rdHit && regAddr == psim_pkg::PEND_OFS
      |=> dataOe && dataOut == {20'h00000, $past(s_r.pend)})
      else $error("pending read wrong");
   pend_route_a: assert property (1'b1
      |=> s_r.pend == (psimRoute(~$past(slotLine_n)) & ~$past(s_r.mask)))
      else $error("pending bits not set per line and mask");
   line_three_a: assert property (slotLine_n == 4'he && s_r.mask == 12'h000
      |=> $countones(s_r.pend) == 3)
      else $error("one line did not set three bits");
   masked_quiet_a: assert property (s_r.mask == 12'hfff |=> ##1 pciIrqToHost_n)
      else $error("masked sources reached the host");
   irq_out_a: assert property (|(s_r.pend & ~s_r.mask) |=> !pciIrqToHost_n)
      else $error("unmasked pending did not raise the request");
   reset_clear_a: assert property ($rose(rst_n) |-> s_r.mask == 12'h000
      && pciIrqToHost_n)
      else $error("mask not cleared by reset");
   no_path_a: assert property (!gIf.irqCtrlOk |=> !dataOe)
      else $error("register driven outside its live buffered region");

   // ==========================================================
   // bus answer and line checks
   // these pin down each path on its own so one broken term is named

   rd_answer_a: assert property (rdHit |=> dataOe)
      else $error("read strobe got no answer");

   rd_idle_a: assert property (!rdHit |=> !dataOe)
      else $error("data driven without a read");

   rd_zero_a: assert property (!rdHit |=> dataOut == 32'h00000000)
      else $error("read data not zero outside a read");

   other_ofs_a: assert property (rdHit && regAddr != psim_pkg::PEND_OFS
      && regAddr != psim_pkg::MASK_OFS |=> dataOut == 32'h00000000)
      else $error("unmapped offset did not read zero");

   upper_zero_a: assert property (1'b1 |-> dataOut[31:12] == 20'h00000)
      else $error("unimplemented bits read nonzero");

   pend_ro_a: assert property (wrHit && regAddr == psim_pkg::PEND_OFS
      |=> $stable(s_r.mask))
      else $error("pending write disturbed the mask");

   wr_other_a: assert property (wrHit && regAddr != psim_pkg::MASK_OFS
      |=> $stable(s_r.mask))
      else $error("write to another offset changed the mask");

   wr_refused_a: assert property (!gIf.irqCtrlOk |=> $stable(s_r.mask))
      else $error("mask written outside its live region");

   pend_masked_a: assert property ($stable(s_r.mask)
      |-> (s_r.pend & s_r.mask) == 12'h000)
      else $error("masked source left a pending bit");

   all_masked_a: assert property (s_r.mask == 12'hfff |=> s_r.pend == 12'h000)
      else $error("full mask still let a pending bit through");

   irq_idle_a: assert property (!(|(s_r.pend & ~s_r.mask)) |=> pciIrqToHost_n)
      else $error("host request without unmasked pending");

   irq_cause_a: assert property (!pciIrqToHost_n
      |-> $past(|(s_r.pend & ~s_r.mask)))
      else $error("host request raised with no cause");

   no_line_a: assert property (slotLine_n == 4'hf |=> s_r.pend == 12'h000)
      else $error("pending set with all lines idle");

   pend_cause_a: assert property (|s_r.pend |-> $past(slotLine_n != 4'hf))
      else $error("pending bit without an active line");

   slot_layout_a: assert property (slotLine_n == 4'he && s_r.mask == 12'h000
      |=> s_r.pend == 12'h481)
      else $error("line A did not light bits 0, 7 and 10");

   reset_out_a: assert property ($rose(rst_n) |-> !dataOe && dataOut == 32'h00000000
      && s_r.pend == 12'h000)
      else $error("outputs not quiet after reset");

   sel_pair_a: assert property (gIf.irqCtrlOk |-> !chipSel_n[psim_pkg::IRQ_CS_IDX]
      && !regionDisable[psim_pkg::IRQ_CS_IDX])
      else $error("controller qualified without its live select");

   xcvr_follow_a: assert property (gIf.irqCtrlOk |=> !xcvrEnable_n)
      else $error("transceivers shut during a controller access");

   cfg_open_a: assert property (hardResetCfg |=> !xcvrEnable_n)
      else $error("transceivers shut during reset configuration");

   oe_cause_a: assert property (dataOe |-> $past(rdHit))
      else $error("data enable without a sampled read");
endmodule

// *** psim_slot_model.sv ***
// slot board model: the four shared open-drain interrupt lines
// assumes pull-ups on the lines and requests chosen by the bench
`timescale 1ns/1ps
module psim_slot_model (
   input wire logic [3:0] req,
   output logic [3:0] slotLine_n
);
   // ========================================
   // line drive
   // a released line goes to its pull-up, so it never keeps a stale low
   assign slotLine_n = ~req;
endmodule

// *** tb_top.sv ***
// self-checking bench for the slot interrupt controller
// assumes psim_pkg and the slot model are compiled before it
`timescale 1ns/1ps
module tb_top;
   logic clk, rst_n = 1'b0, writeEn_n = 1'b1, readEn_n = 1'b1, hardResetCfg = 1'b0;
   logic [7:0] chipSel_n = 8'hff, regionDisable = 8'h00;
   logic [3:0] regAddr = 4'h0, req = 4'h0, slotLine_n;
   logic [31:0] dataIn = 32'h0, dataOut, seed = 32'h43;
   logic dataOe, pciIrqToHost_n, xcvrEnable_n;
   int errors = 0, samplesChecked = 0;
   psim_irq_ctrl i_dut (.clk, .rst_n, .chipSel_n, .regionDisable, .hardResetCfg,
      .regAddr, .writeEn_n, .readEn_n, .dataIn, .dataOut, .dataOe, .slotLine_n,
      .pciIrqToHost_n, .xcvrEnable_n);
   psim_slot_model i_slots (.req, .slotLine_n);
   // ========================================
   // helpers
   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // line L reaches slot s on pin p where L = (p + s) mod 4
   function automatic logic [11:0] pend(input logic [3:0] l, input logic [11:0] m);
      for (int s = 0; s < 3; s++) begin
         for (int p = 0; p < 4; p++) begin
            pend[s * 4 + p] = l[(p + s) % 4];
         end
      end
      return pend & ~m;
   endfunction
   task chk(input logic [31:0] got, input logic [31:0] exp);
      samplesChecked++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task finish_test();
      if (errors == 0 && samplesChecked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // one strobed cycle; registered answer is sampled just after release, before the next edge
   task acc(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(negedge clk);
      chipSel_n[3] = 1'b0;
      regAddr = a;
      dataIn = d;
      writeEn_n = ~w;
      readEn_n = w;
      @(negedge clk);
      chipSel_n = 8'hff;
      writeEn_n = 1'b1;
      readEn_n = 1'b1;
   endtask
   task rd(input logic [3:0] a, input logic [31:0] e);
      acc(1'b0, a, 32'h0);
      chk({31'h0, dataOe}, 32'h1);
      chk(dataOut, e);
   endtask
   // ========================================
   // stimulus
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial begin
      repeat (2000) @(posedge clk);
      errors++;
      finish_test();
   end
   initial begin
      logic [31:0] r, m;
      logic [3:0] l;
      repeat (10) @(negedge clk);
      rst_n = 1'b1;
      rd(4'h4, 32'h0);
      rd(4'h0, 32'h0);
      rd(4'h8, 32'h0);
      acc(1'b1, 4'h4, 32'hffffffff);
      rd(4'h4, 32'h00000fff);
      acc(1'b1, 4'h0, 32'h0);
      rd(4'h4, 32'h00000fff);
      regionDisable[3] = 1'b1;
      acc(1'b1, 4'h4, 32'h0);
      acc(1'b0, 4'h4, 32'h0);
      chk({31'h0, dataOe | ~xcvrEnable_n}, 32'h0);
      regionDisable[3] = 1'b0;
      rd(4'h4, 32'h00000fff);
      for (int i = 0; i < 16; i++) begin
         @(negedge clk);
         m = rnd();
         chipSel_n = ~(8'h01 << i[2:0]);
         regionDisable = m[7:0];
         hardResetCfg = (i > 13);
         @(negedge clk);
         chk({31'h0, xcvrEnable_n}, {31'h0, ~(hardResetCfg
            | (psim_pkg::BUF_CS_MAP[i[2:0]] & ~m[i[2:0]]))});
      end
      chipSel_n = 8'hff;
      regionDisable = 8'h00;
      hardResetCfg = 1'b0;
      for (int i = 0; i < 40; i++) begin
         r = rnd();
         m = (i < 4) ? 32'h0 : (i == 39) ? 32'hffffffff : rnd();
         l = (i < 4) ? 4'h1 << i[1:0] : (i == 39) ? 4'hf : r[3:0];
         acc(1'b1, 4'h4, m);
         @(negedge clk);
         req = l;
         repeat (2) @(negedge clk);
         chk({31'h0, pciIrqToHost_n}, {31'h0, ~|pend(l, m[11:0])});
         rd(4'h0, {20'h0, pend(l, m[11:0])});
         rd(4'h4, {20'h0, m[11:0]});
      end
      finish_test();
   end
endmodule
